// >>> verilog/serial_prog_regs.vh
// command codes, setup codes and status layout of the serial programming decoder
`ifndef SERIAL_PROG_REGS_VH
`define SERIAL_PROG_REGS_VH
`define SETUP_UART      8'h86
`define SETUP_SIO       8'h30
`define CMD_ERASE       8'hF0
`define CMD_WRITE       8'h30
`define CMD_READ        8'h40
`define CMD_RAM_LOAD    8'h60
`define CMD_SUM         8'h90
`define CMD_ID          8'hC0
`define CMD_STATUS      8'hC3
`define CMD_LOCK        8'hFA
`define CMD_CLK_CHANGE  8'hA0
`define ERASED_BYTE     8'hFF
`define AREA_CHIP_MIN   8'h80
`define STAT_LOCK_BIT   0
`define STAT_TAIL_BIT   1
`define ID_ROM_DEFAULT  8'h5A
`define ID_RAM_DEFAULT  8'hA5
`endif

// >>> verilog/serial_link.v
// serial bit engine: pin synchronisers, auto-baud asynchronous path and clocked slave path
`timescale 1ns/1ps
`include "serial_prog_regs.vh"
module serial_link #(
	parameter CNT_W = 17
) (
	input  wire       core_clk,
	input  wire       rst_n,
	input  wire       rx_pin,
	input  wire       sclk_pin,
	input  wire       fmt_set,
	input  wire       fmt_sio,
	input  wire       remeasure,
	input  wire       flow_busy,
	input  wire       tx_valid,
	input  wire [7:0] tx_data,
	output wire       tx_ready,
	output reg        rx_valid,
	output reg  [7:0] rx_data,
	output reg        rx_sio,
	output reg        tx_pin
);
	localparam U_IDLE  = 4'b0001;
	localparam U_MEAS  = 4'b0010;
	localparam U_START = 4'b0100;
	localparam U_DATA  = 4'b1000;

	reg [2:0]       rx_s;
	reg [2:0]       ck_s;
	reg             rx_f;
	reg             ck_f;
	reg             rx_prev;
	reg             ck_prev;
	reg [3:0]       ust;
	reg [CNT_W-1:0] ucnt;
	reg [CNT_W-1:0] bit_len;
	reg [3:0]       uidx;
	reg [7:0]       ushf;
	reg             meas_pend;
	reg [7:0]       sshf;
	reg [3:0]       scnt;
	reg [9:0]       tsh;
	reg [3:0]       tbits;
	reg [CNT_W-1:0] tcnt;
	wire            rx_fall  = rx_prev & ~rx_f;
	wire            ck_rise  = ~ck_prev & ck_f;
	wire            ck_fall  = ck_prev & ~ck_f;
	wire            uart_en  = ~(fmt_set & fmt_sio);
	wire            sio_en   = ~(fmt_set & ~fmt_sio);
	wire [CNT_W-1:0] reload  = bit_len - {{(CNT_W-1){1'b0}}, 1'b1};

	assign tx_ready = (tbits == 4'h0);

	always @(posedge core_clk) begin
		if (!rst_n) begin
			rx_s    <= 3'h7;
			ck_s    <= 3'h7;
			rx_f    <= 1'b1;
			ck_f    <= 1'b1;
			rx_prev <= 1'b1;
			ck_prev <= 1'b1;
		end else begin
			rx_s    <= {rx_s[1:0], rx_pin};
			ck_s    <= {ck_s[1:0], sclk_pin};
			// a change counts only once the last two stages agree
			if (rx_s[1] == rx_s[2])
				rx_f <= rx_s[2];
			if (ck_s[1] == ck_s[2])
				ck_f <= ck_s[2];
			rx_prev <= rx_f;
			ck_prev <= ck_f;
		end
	end

	always @(posedge core_clk) begin
		if (!rst_n) begin
			ust       <= U_IDLE;
			ucnt      <= {CNT_W{1'b0}};
			bit_len   <= {CNT_W{1'b1}};
			uidx      <= 4'h0;
			ushf      <= 8'h00;
			meas_pend <= 1'b1;
			sshf      <= 8'h00;
			scnt      <= 4'h0;
			rx_valid  <= 1'b0;
			rx_data   <= 8'h00;
			rx_sio    <= 1'b0;
		end else begin
			rx_valid <= 1'b0;
			if (remeasure) begin
				meas_pend <= 1'b1;
				ust       <= U_IDLE;
			end else begin
				case (ust)
				U_IDLE: begin
					if (uart_en && rx_fall) begin
						ucnt <= meas_pend ? {CNT_W{1'b0}} : {1'b0, bit_len[CNT_W-1:1]};
						ust  <= meas_pend ? U_MEAS : U_START;
					end
				end
				U_MEAS: begin
					// low run of the setup byte is start bit plus bit 0: two bit times
					if (rx_f) begin
						bit_len   <= {1'b0, ucnt[CNT_W-1:1]};
						ucnt      <= {2'b00, ucnt[CNT_W-1:2]};
						ushf      <= 8'h00;
						uidx      <= 4'h1;
						meas_pend <= 1'b0;
						ust       <= U_DATA;
					end else if (ucnt != {CNT_W{1'b1}}) begin
						ucnt <= ucnt + {{(CNT_W-1){1'b0}}, 1'b1};
					end
				end
				U_START: begin
					if (ucnt != {CNT_W{1'b0}}) begin
						ucnt <= ucnt - {{(CNT_W-1){1'b0}}, 1'b1};
					end else if (!rx_f) begin
						ucnt <= reload;
						uidx <= 4'h0;
						ust  <= U_DATA;
					end else begin
						ust <= U_IDLE;
					end
				end
				U_DATA: begin
					if (ucnt != {CNT_W{1'b0}}) begin
						ucnt <= ucnt - {{(CNT_W-1){1'b0}}, 1'b1};
					end else if (uidx == 4'h8) begin
						rx_valid <= 1'b1;
						rx_data  <= ushf;
						rx_sio   <= 1'b0;
						ust      <= U_IDLE;
					end else begin
						ushf[uidx[2:0]] <= rx_f;
						uidx            <= uidx + 4'h1;
						ucnt            <= reload;
					end
				end
				default: ust <= U_IDLE;
				endcase
			end
			// clocked slave path samples on the rising edge of the controller's clock
			if (sio_en && ck_rise) begin
				sshf <= {rx_f, sshf[7:1]};
				if (scnt == 4'h7) begin
					scnt     <= 4'h0;
					rx_valid <= 1'b1;
					rx_data  <= {rx_f, sshf[7:1]};
					rx_sio   <= 1'b1;
				end else begin
					scnt <= scnt + 4'h1;
				end
			end
		end
	end

	always @(posedge core_clk) begin
		if (!rst_n) begin
			tsh    <= 10'h3FF;
			tbits  <= 4'h0;
			tcnt   <= {CNT_W{1'b0}};
			tx_pin <= 1'b1;
		end else begin
			if (tx_valid && tx_ready) begin
				tsh   <= fmt_sio ? {2'b11, tx_data} : {1'b1, tx_data, 1'b0};
				tbits <= fmt_sio ? 4'h8 : 4'hA;
				tcnt  <= reload;
			end else if (tbits != 4'h0) begin
				if (fmt_sio) begin
					if (ck_fall) begin
						tsh   <= {1'b1, tsh[9:1]};
						tbits <= tbits - 4'h1;
					end
				end else if (tcnt == {CNT_W{1'b0}}) begin
					tsh   <= {1'b1, tsh[9:1]};
					tbits <= tbits - 4'h1;
					tcnt  <= reload;
				end else begin
					tcnt <= tcnt - {{(CNT_W-1){1'b0}}, 1'b1};
				end
			end
			// idle slave line doubles as flow control: low while the core is busy
			if (fmt_set && fmt_sio && tbits == 4'h0)
				tx_pin <= ~flow_busy;
			else
				tx_pin <= (tbits == 4'h0) ? 1'b1 : tsh[0];
		end
	end
endmodule // serial_link

// >>> verilog/serial_prog_command_decoder.v
// serial programming-mode command interpreter with security lock and password gating
// Overview of operation
// - after reset, accept only a setup byte
// - 0x86 selects asynchronous, 0x30 clocked slave
// - 0xF0 requests flash erase
// - 0x30 after setup requests flash write
// - 0x40 requests flash read
// - 0x60 loads data into on-chip RAM
// - 0x90 sends flash checksum, upper byte first
// - 0xC0 sends ROM and RAM identification bytes
// - 0xC3 reports lock and tail-area status
// - 0xFA turns the security lock on
// - lock refuses write, RAM load, read
// - lock blocks parallel and run writes; chip erase clears
// - chip or sector erase; erased reads 0xFF
// - sector erase halts until reset if locked or option 0xFF
// - erase needs password unless blank or option 0xFF
// - write needs password unless flash blank
// - read sends requested bytes, then checksum
// - read needs password unless flash blank
// - RAM load returns checksum; executes RAM as low byte queued
// - RAM load needs password unless flash blank
// - 0xA0 switches system clock, then re-derives baud in asynchronous format only
// - measure setup byte's first low run for baud
// - echo accepted command bytes; setup error sends nothing
// - password error halts until external reset
`timescale 1ns/1ps
`include "serial_prog_regs.vh"
module serial_prog_command_decoder #(
	parameter       CNT_W       = 17,
	parameter [7:0] ID_ROM_CODE = `ID_ROM_DEFAULT,
	parameter [7:0] ID_RAM_CODE = `ID_RAM_DEFAULT
) (
	input  wire        core_clk,
	input  wire        rst_n,
	input  wire        rx_pin,
	input  wire        sclk_pin,
	output wire        tx_pin,
	input  wire        flash_blank,
	input  wire [7:0]  erase_protect_option_byte,
	input  wire        lock_stored,
	input  wire        tail_blank,
	output wire        auth_req,
	input  wire        auth_ok,
	input  wire        auth_fail,
	output wire        op_req,
	output reg  [7:0]  op_code,
	output reg         erase_chip,
	input  wire        op_done,
	input  wire        op_err,
	input  wire [15:0] op_sum,
	input  wire        eng_tx_valid,
	input  wire [7:0]  eng_tx_data,
	output wire        eng_tx_ready,
	output reg  [7:0]  rx_byte,
	output reg         rx_byte_valid,
	output reg         cmd_refused,
	output reg         ram_exec,
	output reg         security_lock,
	output wire        parallel_access_block,
	output wire        run_write_block,
	output reg         ext_clk_sel,
	output reg         fmt_sio,
	output wire        halted
);
	localparam ST_STANDBY = 14'h0001;
	localparam ST_CMD     = 14'h0002;
	localparam ST_SEND    = 14'h0004;
	localparam ST_AUTH    = 14'h0008;
	localparam ST_AREA    = 14'h0010;
	localparam ST_RUN     = 14'h0020;
	localparam ST_SUMH    = 14'h0040;
	localparam ST_SUML    = 14'h0080;
	localparam ST_ID1     = 14'h0100;
	localparam ST_ID2     = 14'h0200;
	localparam ST_STAT    = 14'h0400;
	localparam ST_CLK     = 14'h0800;
	localparam ST_REF     = 14'h1000;
	localparam ST_HALT    = 14'h2000;

	reg [13:0] state;
	reg [13:0] pend;
	reg [13:0] after_auth;
	reg        fmt_set;
	reg [7:0]  tx_byte;
	reg        tx_hold;
	reg [15:0] sum;
	reg        remeasure;
	wire       link_ready;
	wire       link_rx_valid;
	wire [7:0] link_rx_data;
	wire       link_rx_sio;
	wire       in_run    = (state == ST_RUN);
	wire       tx_valid  = in_run ? eng_tx_valid : tx_hold;
	wire [7:0] tx_data   = in_run ? eng_tx_data : tx_byte;
	wire       tx_fire   = (state == ST_SEND) && tx_hold && link_ready;
	wire       option_ff = (erase_protect_option_byte == `ERASED_BYTE);

	// password is skipped on a blank part; erase also skips it on an open option byte
	function need_auth;
		input [7:0] cmd;
		input       blank;
		input       opt_ff;
		begin
			if (cmd == `CMD_ERASE)
				need_auth = ~(blank | opt_ff);
			else
				need_auth = ~blank;
		end
	endfunction

	assign auth_req              = (state == ST_AUTH);
	assign op_req                = in_run;
	assign eng_tx_ready          = in_run & link_ready;
	assign parallel_access_block = security_lock;
	assign run_write_block       = security_lock;
	assign halted                = (state == ST_HALT);

	serial_link #(
		.CNT_W(CNT_W)
	) u_link (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.rx_pin    (rx_pin),
		.sclk_pin  (sclk_pin),
		.fmt_set   (fmt_set),
		.fmt_sio   (fmt_sio),
		.remeasure (remeasure),
		.flow_busy (~(state == ST_CMD || state == ST_STANDBY)),
		.tx_valid  (tx_valid),
		.tx_data   (tx_data),
		.tx_ready  (link_ready),
		.rx_valid  (link_rx_valid),
		.rx_data   (link_rx_data),
		.rx_sio    (link_rx_sio),
		.tx_pin    (tx_pin)
	);

	always @(posedge core_clk) begin
		if (!rst_n) begin
			state         <= ST_STANDBY;
			pend          <= ST_CMD;
			after_auth    <= ST_RUN;
			fmt_set       <= 1'b0;
			fmt_sio       <= 1'b0;
			tx_byte       <= 8'h00;
			tx_hold       <= 1'b0;
			sum           <= 16'h0000;
			remeasure     <= 1'b0;
			op_code       <= 8'h00;
			erase_chip    <= 1'b0;
			rx_byte       <= 8'h00;
			rx_byte_valid <= 1'b0;
			cmd_refused   <= 1'b0;
			ram_exec      <= 1'b0;
			security_lock <= 1'b0;
			ext_clk_sel   <= 1'b0;
		end else begin
			remeasure     <= 1'b0;
			cmd_refused   <= 1'b0;
			ram_exec      <= 1'b0;
			rx_byte_valid <= 1'b0;
			// payload bytes reach the engine only during the password check and while it owns the exchange
			if (link_rx_valid && (state == ST_AUTH || state == ST_RUN)) begin
				rx_byte       <= link_rx_data;
				rx_byte_valid <= 1'b1;
			end
			if (tx_fire)
				tx_hold <= 1'b0;
			case (state)
			ST_STANDBY: begin
				// stored lock is taken after reset release, not under reset
				security_lock <= lock_stored;
				if (link_rx_valid) begin
					if (!link_rx_sio && link_rx_data == `SETUP_UART) begin
						fmt_set <= 1'b1;
						fmt_sio <= 1'b0;
						tx_byte <= link_rx_data;
						tx_hold <= 1'b1;
						pend    <= ST_CMD;
						state   <= ST_SEND;
					end else if (link_rx_sio && link_rx_data == `SETUP_SIO) begin
						fmt_set <= 1'b1;
						fmt_sio <= 1'b1;
						tx_byte <= link_rx_data;
						tx_hold <= 1'b1;
						pend    <= ST_CMD;
						state   <= ST_SEND;
					end else begin
						// a rejected byte may have left a false bit time; measure afresh
						remeasure <= 1'b1;
					end
				end
			end
			ST_CMD: begin
				if (link_rx_valid && (!fmt_sio == !link_rx_sio)) begin
					op_code <= link_rx_data;
					tx_byte <= link_rx_data;
					case (link_rx_data)
					`CMD_ERASE: begin
						tx_hold    <= 1'b1;
						after_auth <= ST_AREA;
						pend       <= need_auth(link_rx_data, flash_blank, option_ff) ? ST_AUTH : ST_AREA;
						state      <= ST_SEND;
					end
					`CMD_WRITE, `CMD_READ, `CMD_RAM_LOAD: begin
						if (security_lock) begin
							cmd_refused <= 1'b1;
						end else begin
							tx_hold    <= 1'b1;
							after_auth <= ST_RUN;
							pend       <= need_auth(link_rx_data, flash_blank, option_ff) ? ST_AUTH : ST_RUN;
							state      <= ST_SEND;
						end
					end
					`CMD_SUM: begin
						tx_hold <= 1'b1;
						pend    <= ST_RUN;
						state   <= ST_SEND;
					end
					`CMD_ID: begin
						tx_hold <= 1'b1;
						pend    <= ST_ID1;
						state   <= ST_SEND;
					end
					`CMD_STATUS: begin
						tx_hold <= 1'b1;
						pend    <= ST_STAT;
						state   <= ST_SEND;
					end
					`CMD_LOCK: begin
						security_lock <= 1'b1;
						tx_hold       <= 1'b1;
						pend          <= ST_CMD;
						state         <= ST_SEND;
					end
					`CMD_CLK_CHANGE: begin
						tx_hold <= 1'b1;
						pend    <= ST_CLK;
						state   <= ST_SEND;
					end
					default: state <= ST_CMD;
					endcase
				end
			end
			ST_SEND: begin
				if (tx_fire)
					state <= pend;
			end
			ST_AUTH: begin
				if (auth_fail)
					state <= ST_HALT;
				else if (auth_ok)
					state <= after_auth;
			end
			ST_AREA: begin
				if (link_rx_valid) begin
					if (link_rx_data >= `AREA_CHIP_MIN) begin
						erase_chip <= 1'b1;
						state      <= ST_RUN;
					end else if (security_lock || option_ff) begin
						state <= ST_HALT;
					end else begin
						erase_chip <= 1'b0;
						state      <= ST_RUN;
					end
				end
			end
			ST_RUN: begin
				// engine streams records or read data; this side only frames the exchange
				if (op_err) begin
					state <= ST_HALT;
				end else if (op_done) begin
					sum   <= op_sum;
					state <= ST_SUMH;
					if (op_code == `CMD_ERASE && erase_chip)
						security_lock <= 1'b0;
				end
			end
			ST_SUMH: begin
				tx_byte <= sum[15:8];
				tx_hold <= 1'b1;
				pend    <= ST_SUML;
				state   <= ST_SEND;
			end
			ST_SUML: begin
				tx_byte <= sum[7:0];
				tx_hold <= 1'b1;
				// control passes to the loaded program as the low RAM checksum byte is queued, before it is sent
				pend    <= (op_code == `CMD_RAM_LOAD) ? ST_HALT : ST_CMD;
				if (op_code == `CMD_RAM_LOAD)
					ram_exec <= 1'b1;
				state   <= ST_SEND;
			end
			ST_ID1: begin
				tx_byte <= ID_ROM_CODE;
				tx_hold <= 1'b1;
				pend    <= ST_ID2;
				state   <= ST_SEND;
			end
			ST_ID2: begin
				tx_byte <= ID_RAM_CODE;
				tx_hold <= 1'b1;
				pend    <= ST_CMD;
				state   <= ST_SEND;
			end
			ST_STAT: begin
				tx_byte                 <= 8'h00;
				tx_byte[`STAT_LOCK_BIT] <= security_lock;
				tx_byte[`STAT_TAIL_BIT] <= tail_blank;
				tx_hold                 <= 1'b1;
				pend                    <= ST_CMD;
				state                   <= ST_SEND;
			end
			ST_CLK: begin
				// wait for the echo to leave before the bit rate changes under it
				if (link_ready) begin
					ext_clk_sel <= ~ext_clk_sel;
					remeasure   <= ~fmt_sio;
					state       <= fmt_sio ? ST_CMD : ST_REF;
				end
			end
			ST_REF: begin
				if (link_rx_valid)
					state <= ST_CMD;
			end
			ST_HALT: begin
				state <= ST_HALT;
			end
			default: state <= ST_STANDBY;
			endcase
		end
	end
endmodule // serial_prog_command_decoder

// >>> verif/serial_prog_checker.sv
// port assertions for the serial programming decoder
`timescale 1ns/1ps
module serial_prog_checker (
	input wire       core_clk,
	input wire       rst_n,
	input wire       auth_req,
	input wire       auth_fail,
	input wire       op_req,
	input wire [7:0] op_code,
	input wire       erase_chip,
	input wire       op_done,
	input wire       eng_tx_ready,
	input wire       cmd_refused,
	input wire       ram_exec,
	input wire       security_lock,
	input wire       parallel_access_block,
	input wire       run_write_block,
	input wire [7:0] erase_protect_option_byte,
	input wire       halted
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence s_pw_bad;
		auth_req && auth_fail;
	endsequence
	sequence s_chip_end;
		op_req && op_code == 8'hF0 && erase_chip && op_done;
	endsequence
	AST_BLOCK_MIRROR: assert property (parallel_access_block == security_lock && run_write_block == security_lock)
		else $error("block outputs differ from lock");
	AST_CHIP_CLEARS_LOCK: assert property (s_chip_end |=> !security_lock)
		else $error("chip erase left lock on");
	AST_PW_FAIL_HALT: assert property (s_pw_bad |=> halted [*8])
		else $error("no halt after password failure");
	AST_HALT_STICKY: assert property (halted |=> halted)
		else $error("halt left without reset");
	AST_LOCKED_OPS: assert property (op_req && (op_code == 8'h30 || op_code == 8'h40 || op_code == 8'h60)
		|-> !security_lock)
		else $error("locked operation started");
	AST_REFUSE_PULSE: assert property (cmd_refused |-> (security_lock && !op_req) ##1 !cmd_refused)
		else $error("refusal pulse wrong");
	AST_SECTOR_GATE: assert property (op_req && op_code == 8'hF0 && !erase_chip
		|-> !security_lock && erase_protect_option_byte != 8'hFF)
		else $error("sector erase not refused");
	AST_RAM_EXEC: assert property (ram_exec |-> op_code == 8'h60)
		else $error("execute pulse without ram load");
	AST_ENG_IN_RUN: assert property (eng_tx_ready |-> op_req && !auth_req)
		else $error("engine stream open outside run");
endmodule // serial_prog_checker

bind serial_prog_command_decoder serial_prog_checker chk (.core_clk, .rst_n, .auth_req, .auth_fail, .op_req,
	.op_code, .erase_chip, .op_done, .eng_tx_ready, .cmd_refused, .ram_exec, .security_lock,
	.parallel_access_block, .run_write_block, .erase_protect_option_byte, .halted);

// >>> verif/prog_controller.sv
// asynchronous and clocked slave programming controller model
`timescale 1ns/1ps
module prog_controller #(
	parameter int BIT      = 40,
	parameter int SIO_HALF = 8
) (
	input  wire  core_clk,
	input  wire  tx_pin,
	output logic rx_pin,
	output logic sclk_pin
);
	logic [7:0] rxq[$];
	initial begin
		rx_pin = 1'b1;
		sclk_pin = 1'b1;
	end
	// slave transfer: reply bit read before each falling clock edge, data taken on the rise
	task automatic sio_xfer(input logic [7:0] b, output logic [7:0] r);
		for (int i = 0; i < 8; i++) begin
			@(negedge core_clk);
			r[i] = tx_pin;
			sclk_pin = 1'b0;
			rx_pin = b[i];
			repeat (SIO_HALF - 1) @(negedge core_clk);
			sclk_pin = 1'b1;
			repeat (SIO_HALF - 1) @(negedge core_clk);
		end
		@(negedge core_clk);
		rx_pin = 1'b1;
	endtask
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(negedge core_clk);
			rx_pin = f[i];
			repeat (BIT - 1) @(negedge core_clk);
		end
	endtask
	// samples at bit centres; no stop check, a framing slip shows as a wrong byte
	initial begin
		logic [7:0] b;
		forever begin
			@(negedge core_clk);
			if (tx_pin === 1'b0) begin
				repeat (BIT / 2) @(negedge core_clk);
				for (int i = 0; i < 8; i++) begin
					repeat (BIT) @(negedge core_clk);
					b[i] = tx_pin;
				end
				repeat (BIT) @(negedge core_clk);
				rxq.push_back(b);
			end
		end
	end
endmodule // prog_controller

// >>> verif/testbench.sv
// self-checking bench for the serial programming decoder
`timescale 1ns/1ps
module testbench;
	localparam int BIT = 40;
	logic core_clk = 0, rst_n = 0, flash_blank = 1, tail_blank = 1, lock_stored = 0, auth_ok = 0, auth_fail = 0;
	logic op_done = 0, op_err = 0, eng_tx_valid = 0, sclk_pin, rx_byte_valid;
	logic [7:0]  opt = 8'h00, eng_tx_data = 8'h00, op_code, rx_byte, last_rx = 8'h00;
	logic [15:0] op_sum = 16'h0000;
	logic rx_pin, tx_pin, auth_req, op_req, erase_chip, eng_tx_ready, cmd_refused, ram_exec, security_lock;
	logic parallel_access_block, run_write_block, ext_clk_sel, fmt_sio, halted;
	int n_errors = 0, checks = 0, cyc = 0, n_ref = 0;
	always #2.5 core_clk = ~core_clk;
	prog_controller #(.BIT(BIT)) pc (.core_clk, .tx_pin, .rx_pin, .sclk_pin);
	serial_prog_command_decoder DUT (.core_clk, .rst_n, .rx_pin, .sclk_pin, .tx_pin, .flash_blank,
		.erase_protect_option_byte(opt), .lock_stored, .tail_blank, .auth_req, .auth_ok, .auth_fail, .op_req,
		.op_code, .erase_chip, .op_done, .op_err, .op_sum, .eng_tx_valid, .eng_tx_data, .eng_tx_ready,
		.rx_byte, .rx_byte_valid, .cmd_refused, .ram_exec, .security_lock, .parallel_access_block,
		.run_write_block, .ext_clk_sel, .fmt_sio, .halted);
	always @(posedge core_clk) if (cmd_refused === 1'b1) n_ref <= n_ref + 1;
	always @(posedge core_clk) if (rx_byte_valid === 1'b1) last_rx <= rx_byte;
	task automatic tally_and_finish();
		$display("checks %0d, n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// hang guard, sized well above the full run
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 60000) begin
			n_errors++;
			tally_and_finish();
		end
	end
	task automatic chk_byte(string what, logic [7:0] exp, logic [7:0] got);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_bit(string what, logic exp, logic got);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic expect_rx(logic [7:0] exp);
		for (int i = 0; i < 30 * BIT && pc.rxq.size() == 0; i++) @(negedge core_clk);
		chk_bit("reply present", 1'b1, pc.rxq.size() != 0);
		if (pc.rxq.size() != 0) chk_byte("reply", exp, pc.rxq.pop_front());
	endtask
	task automatic expect_none();
		repeat (30 * BIT) @(negedge core_clk);
		chk_bit("no reply", 1'b1, pc.rxq.size() == 0);
		pc.rxq.delete();
	endtask
	task automatic cmd(logic [7:0] b);
		pc.send_byte(b);
		expect_rx(b);
	endtask
	task automatic wait_hi(int auth);
		for (int i = 0; i < 4000 && (auth ? auth_req : op_req) !== 1'b1; i++) @(negedge core_clk);
		chk_bit(auth ? "auth_req" : "op_req", 1'b1, auth ? auth_req : op_req);
	endtask
	task automatic finish_op(logic [15:0] s);
		op_sum = s;
		op_done = 1'b1;
		@(negedge core_clk);
		op_done = 1'b0;
		expect_rx(s[15:8]);
		expect_rx(s[7:0]);
	endtask
	task automatic pulse_auth(logic ok);
		auth_ok = ok;
		auth_fail = !ok;
		@(negedge core_clk);
		auth_ok = 1'b0;
		auth_fail = 1'b0;
	endtask
	task automatic report(string name);
		$display("test %s done, n_errors %0d", name, n_errors);
	endtask
	task automatic t_setup();
		pc.send_byte(8'h55);
		expect_none();
		cmd(8'h86);
		chk_bit("fmt_sio", 1'b0, fmt_sio);
		report("setup");
	endtask
	task automatic t_id();
		pc.send_byte(8'h11);
		expect_none();
		cmd(8'hC0);
		expect_rx(8'h5A);
		expect_rx(8'hA5);
		report("id");
	endtask
	task automatic t_sum();
		cmd(8'h90);
		wait_hi(0);
		chk_byte("op_code", 8'h90, op_code);
		finish_op(16'h1234);
		report("sum");
	endtask
	task automatic t_read();
		cmd(8'h40);
		wait_hi(0);
		chk_bit("auth_req", 1'b0, auth_req);
		pc.send_byte(8'h12);
		chk_byte("rx_byte", 8'h12, last_rx);
		eng_tx_data = 8'hC5;
		eng_tx_valid = 1'b1;
		for (int i = 0; i < 4000; i++) begin
			@(posedge core_clk);
			if (eng_tx_ready === 1'b1) break;
		end
		@(negedge core_clk);
		eng_tx_valid = 1'b0;
		expect_rx(8'hC5);
		finish_op(16'hBE0F);
		report("read");
	endtask
	task automatic t_lock();
		int r0;
		cmd(8'hFA);
		chk_bit("security_lock", 1'b1, security_lock);
		chk_bit("parallel_access_block", 1'b1, parallel_access_block);
		tail_blank = 1'b0;
		cmd(8'hC3);
		expect_rx(8'h01);
		r0 = n_ref;
		pc.send_byte(8'h30);
		expect_none();
		chk_bit("cmd_refused", 1'b1, n_ref == r0 + 1);
		report("lock");
	endtask
	task automatic t_write();
		cmd(8'h30);
		wait_hi(1);
		pulse_auth(1'b1);
		wait_hi(0);
		pc.send_byte(8'h3A);
		chk_byte("record byte", 8'h3A, last_rx);
		finish_op(16'hA55A);
		report("write");
	endtask
	// second reset: stored lock, open option byte, clocked slave format
	task automatic t_slave();
		logic [7:0] r;
		int r0;
		lock_stored = 1'b1;
		opt = 8'hFF;
		rst_n = 1'b0;
		repeat (12) @(negedge core_clk);
		rst_n = 1'b1;
		repeat (8) @(negedge core_clk);
		chk_bit("security_lock", 1'b1, security_lock);
		pc.sio_xfer(8'h30, r);
		repeat (40) @(negedge core_clk);
		pc.sio_xfer(8'hFF, r);
		chk_byte("setup echo", 8'h30, r);
		chk_bit("fmt_sio", 1'b1, fmt_sio);
		r0 = n_ref;
		pc.sio_xfer(8'h40, r);
		repeat (40) @(negedge core_clk);
		chk_bit("cmd_refused", 1'b1, n_ref == r0 + 1);
		chk_bit("flow ready", 1'b1, tx_pin);
		pc.sio_xfer(8'hC3, r);
		repeat (40) @(negedge core_clk);
		pc.sio_xfer(8'hFF, r);
		chk_byte("status echo", 8'hC3, r);
		repeat (40) @(negedge core_clk);
		pc.sio_xfer(8'hFF, r);
		chk_byte("status", 8'h01, r);
		pc.sio_xfer(8'hF0, r);
		repeat (40) @(negedge core_clk);
		pc.sio_xfer(8'h10, r);
		chk_byte("erase echo", 8'hF0, r);
		repeat (40) @(negedge core_clk);
		chk_bit("halted", 1'b1, halted);
		report("slave");
	endtask
	task automatic t_erase();
		flash_blank = 1'b0;
		cmd(8'hF0);
		wait_hi(1);
		pulse_auth(1'b1);
		pc.send_byte(8'h80);
		wait_hi(0);
		chk_bit("erase_chip", 1'b1, erase_chip);
		finish_op(16'h0F0F);
		chk_bit("security_lock", 1'b0, security_lock);
		report("erase");
	endtask
	task automatic t_clk();
		cmd(8'hA0);
		repeat (4 * BIT) @(negedge core_clk);
		pc.send_byte(8'h86);
		expect_none();
		chk_bit("ext_clk_sel", 1'b1, ext_clk_sel);
		t_id();
		report("clock");
	endtask
	task automatic t_pw_fail();
		cmd(8'h40);
		wait_hi(1);
		pulse_auth(1'b0);
		chk_bit("halted", 1'b1, halted);
		pc.send_byte(8'h90);
		expect_none();
		report("password");
	endtask
	initial begin
		repeat (12) @(negedge core_clk);
		rst_n = 1'b1;
		repeat (8) @(negedge core_clk);
		t_setup();
		t_id();
		t_sum();
		t_read();
		t_lock();
		t_erase();
		t_write();
		t_clk();
		t_pw_fail();
		t_slave();
		tally_and_finish();
	end
endmodule // testbench
